// *** design/nfc_consts.svh ***
/*
 * constants of the memory program/erase controller: offsets, field positions,
 * reset values, action codes and timing counts.
 * assumes one 50 MHz clock shared by both ends of the link.
 */
// Functional notes
// - asleep, only configuration register writes take effect
// - config bit 15 selects sleep or normal
// - memory accesses stall while power bit cleared
// - bit 14 enables ready interrupt per sequence
// - software writes bits 13,0 zero, 12 one
// - bits 11:4 count protected sectors from zero
// - protected sector writes accepted but ignored
// - bits 2:1 select hardread level, 11 reserved
// - hardread level held until sequence ends
// - config bit 3 always reads zero
// - codes 51/91 plus one block: single write
// - codes 61/A1: each block writes; 00 ends
// - code 92 plus dummy word erases page
// - code A2: each dummy word erases page
// - running operation stalls next memory/register write
// - software polls busy, waits interrupt, or stalls
// - verify outcome recorded in error flag
// - action changes only from 00; else reset
// - one-shot action returns to idle afterwards
// - entering sleep clears action register
`ifndef NFC_CONSTS_SVH
`define NFC_CONSTS_SVH

// ----------------------------------------
// register indices (word addresses)
// ----------------------------------------
`define NFC_CFG_IDX 16'h0000
`define NFC_PROG_IDX 16'h0001
`define NFC_STAT_IDX 16'h0002

// ----------------------------------------
// configuration fields
// ----------------------------------------
`define NFC_CFG_RESET 16'h9000
`define NFC_CFG_RO_MASK 16'h0008
`define NFC_CFG_POWER 15
`define NFC_CFG_IRQ 14
`define NFC_CFG_PROT_HI 11
`define NFC_CFG_PROT_LO 4
`define NFC_CFG_HR_HI 2
`define NFC_CFG_HR_LO 1

// ----------------------------------------
// status fields
// ----------------------------------------
`define NFC_ST_BUSY 0
`define NFC_ST_SLEEP 1
`define NFC_ST_VERIFY_ERROR_FLAG 2
`define NFC_ST_HR_LO 3

// ----------------------------------------
// action codes and fields
// ----------------------------------------
`define NFC_ACT_IDLE 8'h00
`define NFC_ACT_WR_ONCE_V 8'h51
`define NFC_ACT_WR_ONCE 8'h91
`define NFC_ACT_WR_CONT_V 8'h61
`define NFC_ACT_WR_CONT 8'ha1
`define NFC_ACT_ER_ONCE 8'h92
`define NFC_ACT_ER_CONT 8'ha2
`define NFC_OPT_WRITE 4'h1
`define NFC_OPT_ERASE 4'h2
`define NFC_SHOT_ONCE 2'h1
`define NFC_VFY_AUTO 2'h1

// ----------------------------------------
// array geometry: 4-word block, 64-word page, 128-word sector
// ----------------------------------------
`define NFC_MEM_WORDS 512
`define NFC_PAGE_WORDS 64
`define NFC_SEC_LSB 7

// ----------------------------------------
// timing
// ----------------------------------------
`define NFC_CLK_NS 20
`define NFC_WRITE_NS 400
`define NFC_WRITE_CYC ((`NFC_WRITE_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_SLEEP_NS 200
`define NFC_SLEEP_CYC ((`NFC_SLEEP_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_WAKE_NS 300
`define NFC_WAKE_CYC ((`NFC_WAKE_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)

// ----------------------------------------
// host-side register byte offsets and read-data word index
// ----------------------------------------
`define NFC_H_CMD 4'h0
`define NFC_H_ADDR 4'h4
`define NFC_H_WDATA 4'h8
`define NFC_H_STAT 4'hc
`define NFC_H_RDATA_IDX 3'h4

`endif

// *** design/nfc_pkg.sv ***
/*
 * types of the memory program/erase controller.
 * assumes nothing of its surroundings.
 */
`default_nettype none
package nfc_pkg;
	typedef enum logic [2:0] {
		NFC_NORMAL_POWER_SETTING,
		NFC_WRITE,
		NFC_ERASE,
		NFC_GO_SLEEP,
		NFC_SLEEP,
		NFC_WAKE
	} nfc_state_t;
endpackage
`default_nettype wire

// *** design/nfc_link_if.sv ***
/*
 * link between processor-side host and the memory controller.
 * assumes both ends on the same clock; request taken on valid and ready.
 */
`default_nettype none
interface nfc_link_if;
	logic req_valid;
	logic req_ready;
	logic req_write;
	logic req_is_reg;
	logic [15:0] req_addr;
	logic [31:0] req_wdata;
	logic rsp_valid;
	logic [31:0] rsp_rdata;
	logic irq;
	modport dev(input req_valid, req_write, req_is_reg, req_addr, req_wdata,
		output req_ready, rsp_valid, rsp_rdata, irq);
	modport host(output req_valid, req_write, req_is_reg, req_addr, req_wdata,
		input req_ready, rsp_valid, rsp_rdata, irq);
endinterface
`default_nettype wire

// *** design/nfc_device.sv ***
/*
 * memory module with its configuration, action and status registers,
 * block write, page erase and sleep sequencing.
 * assumes the host holds a request until req_ready is seen with it.
 */
`include "nfc_consts.svh"
`default_nettype none
module nfc_device (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	nfc_link_if.dev link,
	output logic busy_out,
	output logic sleep_out,
	output logic [1:0] hardread_level_out
);
	nfc_pkg::nfc_state_t state_q;
	logic [15:0] cfg_q;
	logic [7:0] action_q;
	logic verify_error_flag_q;
	logic [1:0] hr_q;
	logic [7:0] cnt_q;
	logic [8:0] base_q;
	logic [31:0] blk_q [4];
	logic [31:0] mem [`NFC_MEM_WORDS];
	logic rsp_valid_q;
	logic [31:0] rsp_rdata_q;
	logic irq_q;

	logic busy;
	logic sleeping;
	logic take;
	logic wr_reg;
	logic wr_mem;
	logic rd_mem;
	logic prot_ok;
	logic start_wr;
	logic start_er;
	logic op_done;
	logic vfy;
	logic [7:0] wsec;
	logic [31:0] stat_word;

	// ----------------------------------------
	// request acceptance and stalling
	// ----------------------------------------
	assign busy = (state_q == nfc_pkg::NFC_WRITE) || (state_q == nfc_pkg::NFC_ERASE)
		|| (state_q == nfc_pkg::NFC_GO_SLEEP) || (state_q == nfc_pkg::NFC_WAKE);
	assign sleeping = (state_q == nfc_pkg::NFC_GO_SLEEP) || (state_q == nfc_pkg::NFC_SLEEP)
		|| (state_q == nfc_pkg::NFC_WAKE);
	// reads of registers never stall so busy can be polled
	always_comb begin
		link.req_ready = 1'b1;
		if (busy && (link.req_write || !link.req_is_reg))
			link.req_ready = 1'b0;
		if (sleeping && !link.req_is_reg)
			link.req_ready = 1'b0;
	end
	assign take = link.req_valid && link.req_ready;
	assign wr_reg = take && link.req_write && link.req_is_reg;
	assign wr_mem = take && link.req_write && !link.req_is_reg;
	assign rd_mem = take && !link.req_write && !link.req_is_reg;

	// ----------------------------------------
	// trigger decode
	// ----------------------------------------
	assign wsec = {6'h00, link.req_addr[8:`NFC_SEC_LSB]};
	assign prot_ok = wsec >= cfg_q[`NFC_CFG_PROT_HI:`NFC_CFG_PROT_LO];
	assign vfy = action_q[7:6] == `NFC_VFY_AUTO;
	// block data arrives in order; last word of the block fires it
	assign start_wr = wr_mem && prot_ok && (action_q[3:0] == `NFC_OPT_WRITE)
		&& (link.req_addr[1:0] == 2'h3);
	assign start_er = wr_mem && prot_ok && (action_q[3:0] == `NFC_OPT_ERASE);
	assign op_done = (state_q == nfc_pkg::NFC_WRITE || state_q == nfc_pkg::NFC_ERASE
		|| state_q == nfc_pkg::NFC_WAKE) && (cnt_q == 8'h00);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_q <= nfc_pkg::NFC_NORMAL_POWER_SETTING;
			cnt_q <= 8'h00;
			base_q <= 9'h000;
		end else begin
			unique case (state_q)
				nfc_pkg::NFC_NORMAL_POWER_SETTING: begin
					if (wr_reg && link.req_addr == `NFC_CFG_IDX
						&& !link.req_wdata[`NFC_CFG_POWER]) begin
						state_q <= nfc_pkg::NFC_GO_SLEEP;
						cnt_q <= 8'(`NFC_SLEEP_CYC - 1);
					end else if (start_wr) begin
						state_q <= nfc_pkg::NFC_WRITE;
						cnt_q <= 8'(`NFC_WRITE_CYC - 1);
						base_q <= {link.req_addr[8:2], 2'h0};
					end else if (start_er) begin
						state_q <= nfc_pkg::NFC_ERASE;
						cnt_q <= 8'(`NFC_PAGE_WORDS - 1);
						base_q <= {link.req_addr[8:6], 6'h00};
					end
				end
				nfc_pkg::NFC_WRITE, nfc_pkg::NFC_ERASE: begin
					if (cnt_q == 8'h00)
						state_q <= nfc_pkg::NFC_NORMAL_POWER_SETTING;
					else
						cnt_q <= cnt_q - 8'h01;
				end
				nfc_pkg::NFC_GO_SLEEP: begin
					// a wake request does not shorten the way down
					if (cnt_q != 8'h00) begin
						cnt_q <= cnt_q - 8'h01;
					end else if (cfg_q[`NFC_CFG_POWER]) begin
						state_q <= nfc_pkg::NFC_WAKE;
						cnt_q <= 8'(`NFC_WAKE_CYC - 1);
					end else begin
						state_q <= nfc_pkg::NFC_SLEEP;
					end
				end
				nfc_pkg::NFC_SLEEP: begin
					if (wr_reg && link.req_addr == `NFC_CFG_IDX
						&& link.req_wdata[`NFC_CFG_POWER]) begin
						state_q <= nfc_pkg::NFC_WAKE;
						cnt_q <= 8'(`NFC_WAKE_CYC - 1);
					end
				end
				nfc_pkg::NFC_WAKE: begin
					if (cnt_q == 8'h00)
						state_q <= nfc_pkg::NFC_NORMAL_POWER_SETTING;
					else
						cnt_q <= cnt_q - 8'h01;
				end
			endcase
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			cfg_q <= `NFC_CFG_RESET;
		else if (wr_reg && link.req_addr == `NFC_CFG_IDX)
			cfg_q <= link.req_wdata[15:0] & ~`NFC_CFG_RO_MASK;
	end

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			action_q <= `NFC_ACT_IDLE;
		end else if (state_q == nfc_pkg::NFC_GO_SLEEP) begin
			action_q <= `NFC_ACT_IDLE;
		end else if (wr_reg && link.req_addr == `NFC_PROG_IDX && !sleeping) begin
			if (action_q != `NFC_ACT_IDLE) begin
				if (link.req_wdata[7:0] != action_q)
					action_q <= `NFC_ACT_IDLE;
			end else begin
				unique case (link.req_wdata[7:0])
					`NFC_ACT_WR_ONCE_V, `NFC_ACT_WR_ONCE, `NFC_ACT_WR_CONT_V,
					`NFC_ACT_WR_CONT, `NFC_ACT_ER_ONCE, `NFC_ACT_ER_CONT:
						action_q <= link.req_wdata[7:0];
					default:
						action_q <= `NFC_ACT_IDLE;
				endcase
			end
		end else if (op_done && state_q != nfc_pkg::NFC_WAKE
			&& action_q[5:4] == `NFC_SHOT_ONCE) begin
			action_q <= `NFC_ACT_IDLE;
		end
	end

	// verify flag: cleared when a verified sequence is armed
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			verify_error_flag_q <= 1'b0;
		end else if (state_q == nfc_pkg::NFC_WRITE && cnt_q == 8'h00 && vfy) begin
			for (int i = 0; i < 4; i++)
				if ((mem[base_q + 9'(i)] & blk_q[i]) != blk_q[i])
					verify_error_flag_q <= 1'b1;
		end else if (wr_reg && link.req_addr == `NFC_PROG_IDX && !sleeping
			&& action_q == `NFC_ACT_IDLE && link.req_wdata[7:6] == `NFC_VFY_AUTO) begin
			verify_error_flag_q <= 1'b0;
		end
	end

	// level latched at each start, held to the end of the sequence
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			hr_q <= 2'h0;
		else if (state_q == nfc_pkg::NFC_NORMAL_POWER_SETTING && (start_wr || start_er))
			hr_q <= cfg_q[`NFC_CFG_HR_HI:`NFC_CFG_HR_LO];
	end

	// ----------------------------------------
	// array and block buffer
	// ----------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (wr_mem && action_q[3:0] == `NFC_OPT_WRITE)
			blk_q[link.req_addr[1:0]] <= link.req_wdata;
		// cells only clear bits; erase is needed to set them
		if (state_q == nfc_pkg::NFC_WRITE && cnt_q == 8'h00)
			for (int i = 0; i < 4; i++)
				mem[base_q + 9'(i)] <= mem[base_q + 9'(i)] & blk_q[i];
		if (state_q == nfc_pkg::NFC_ERASE)
			mem[base_q + 9'(cnt_q)] <= 32'hffff_ffff;
	end

	// ----------------------------------------
	// answers and interrupt
	// ----------------------------------------
	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[`NFC_ST_BUSY] = busy;
		stat_word[`NFC_ST_SLEEP] = sleeping;
		stat_word[`NFC_ST_VERIFY_ERROR_FLAG] = verify_error_flag_q;
		stat_word[`NFC_ST_HR_LO +: 2] = hr_q;
	end

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rsp_valid_q <= 1'b0;
			rsp_rdata_q <= 32'h0000_0000;
		end else begin
			rsp_valid_q <= take && !link.req_write;
			if (rd_mem)
				rsp_rdata_q <= mem[link.req_addr[8:0]];
			else if (take && !link.req_write)
				unique case (link.req_addr)
					`NFC_CFG_IDX: rsp_rdata_q <= {16'h0000, cfg_q};
					`NFC_PROG_IDX: rsp_rdata_q <= {24'h000000, action_q};
					`NFC_STAT_IDX: rsp_rdata_q <= stat_word;
					default: rsp_rdata_q <= 32'h0000_0000;
				endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			irq_q <= 1'b0;
		else
			irq_q <= op_done && cfg_q[`NFC_CFG_IRQ];
	end

	assign link.rsp_valid = rsp_valid_q;
	assign link.rsp_rdata = rsp_rdata_q;
	assign link.irq = irq_q;
	assign busy_out = busy;
	assign sleep_out = sleeping;
	assign hardread_level_out = hr_q;
endmodule
`default_nettype wire

// *** design/nfc_host.sv ***
/*
 * processor-side end: takes orders over an AXI4-Lite slave and issues
 * register and memory accesses on the link.
 * assumes the AXI master keeps each valid and payload until taken.
 */
`include "nfc_consts.svh"
`default_nettype none
module nfc_host (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	nfc_link_if.host link,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic aw_q;
	logic w_q;
	logic [4:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [15:0] addr_q;
	logic [31:0] data_q;
	logic [31:0] rdata_q;
	logic req_q;
	logic write_q;
	logic is_reg_q;
	logic wait_q;
	logic irq_seen_q;
	logic do_wr;

	// ----------------------------------------
	// write channels: held until both arrive
	// ----------------------------------------
	assign s_axi_awready = !aw_q && !s_axi_bvalid;
	assign s_axi_wready = !w_q && !s_axi_bvalid;
	assign do_wr = aw_q && w_q && !s_axi_bvalid;
	assign s_axi_bresp = 2'h0;
	assign s_axi_rresp = 2'h0;

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 5'h00;
			wdata_q <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
			end
			if (do_wr) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// order registers and link request
	// ----------------------------------------
	// a new order while one is pending is dropped, not queued
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			addr_q <= 16'h0000;
			data_q <= 32'h0000_0000;
			req_q <= 1'b0;
			write_q <= 1'b0;
			is_reg_q <= 1'b0;
			wait_q <= 1'b0;
		end else begin
			if (do_wr && awaddr_q[3:0] == `NFC_H_ADDR && s_axi_wstrb != 4'h0)
				addr_q <= wdata_q[15:0];
			if (do_wr && awaddr_q[3:0] == `NFC_H_WDATA && s_axi_wstrb != 4'h0)
				data_q <= wdata_q;
			if (do_wr && awaddr_q[4:2] == 3'h0 && wdata_q[0] && !req_q && !wait_q) begin
				req_q <= 1'b1;
				write_q <= wdata_q[1];
				is_reg_q <= wdata_q[2];
			end else if (req_q && link.req_ready) begin
				req_q <= 1'b0;
				wait_q <= !write_q;
			end else if (link.rsp_valid) begin
				wait_q <= 1'b0;
			end
		end
	end

	// interrupt seen: sticky, write one to clear, a new pulse wins
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			irq_seen_q <= 1'b0;
		else if (link.irq)
			irq_seen_q <= 1'b1;
		else if (do_wr && awaddr_q[3:0] == `NFC_H_STAT && wdata_q[1])
			irq_seen_q <= 1'b0;
	end

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			rdata_q <= 32'h0000_0000;
		else if (link.rsp_valid)
			rdata_q <= link.rsp_rdata;
	end

	assign link.req_valid = req_q;
	assign link.req_write = write_q;
	assign link.req_is_reg = is_reg_q;
	assign link.req_addr = addr_q;
	assign link.req_wdata = data_q;

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			unique case (s_axi_araddr[4:2])
				3'h1: s_axi_rdata <= {16'h0000, addr_q};
				3'h2: s_axi_rdata <= data_q;
				3'h3: s_axi_rdata <= {29'h0, irq_seen_q, wait_q, req_q};
				`NFC_H_RDATA_IDX: s_axi_rdata <= rdata_q;
				default: s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** sim/nfc_link_props.sv ***
/*
 * assertions on the link that joins the host end to the memory controller.
 * assumes one clock and an active-low asynchronous reset for both ends.
 */
`default_nettype none
module nfc_link_props (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic req_write,
	input wire logic req_is_reg,
	input wire logic [15:0] req_addr,
	input wire logic [31:0] req_wdata,
	input wire logic rsp_valid,
	input wire logic [31:0] rsp_rdata,
	input wire logic irq,
	input wire logic busy_out,
	input wire logic sleep_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// busy run length
	// ----------------------------------------
	logic [7:0] busy_cnt_q;
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			busy_cnt_q <= 8'h00;
		end else begin
			busy_cnt_q <= busy_out ? busy_cnt_q + 8'h01 : 8'h00;
		end
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	stall_busy_a: assert property (
		busy_out && req_valid && (req_write || !req_is_reg) |-> !req_ready)
		else $error("request taken while busy");
	sleep_stall_a: assert property (sleep_out && req_valid && !req_is_reg |-> !req_ready)
		else $error("memory access taken while asleep");
	reg_read_a: assert property (req_valid && req_is_reg && !req_write |-> req_ready)
		else $error("register read stalled");
	idle_ready_a: assert property (!busy_out && !sleep_out |-> req_ready)
		else $error("request refused while idle");
	read_answer_a: assert property (req_valid && req_ready && !req_write |=> rsp_valid)
		else $error("read answer missing");
	rsp_cause_a: assert property (
		rsp_valid |-> $past(req_valid && req_ready && !req_write))
		else $error("answer without read");
	req_hold_a: assert property (req_valid && !req_ready |=> req_valid
		&& $stable(req_addr) && $stable(req_wdata) && $stable(req_write))
		else $error("stalled request changed");
	irq_pulse_a: assert property (irq |=> !irq)
		else $error("ready interrupt longer than a cycle");
	// sleep 10, wake 15, write 20, erase 64 cycles
	busy_len_a: assert property (
		$fell(busy_out) |-> busy_cnt_q inside {8'h0a, 8'h0f, 8'h14, 8'h40})
		else $error("busy length wrong");
	cover property ($fell(busy_out));
	cover property (rsp_valid && rsp_rdata == 32'hffff_ffff);
	cover property (irq);
	cover property (sleep_out && req_valid && !req_ready);
	cover property (busy_out && req_valid && !req_ready);
endmodule
`default_nettype wire

// *** sim/nfc_tb_top.sv ***
/*
 * bench of the memory program/erase controller: orders go in over AXI4-Lite
 * to the host end, which drives the device end across the link.
 * assumes a 50 MHz clock and the host register map of the hand-over.
 */
`default_nettype none
module nfc_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, busy, sleep;
	logic [4:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp, hr_lvl;
	int num_errors, num_checks, cyc;
	nfc_link_if u_nfc_link_if();
	nfc_device u_nfc_device(.core_clk_in(clk), .nrst_in(nrst), .link(u_nfc_link_if.dev),
		.busy_out(busy), .sleep_out(sleep), .hardread_level_out(hr_lvl));
	nfc_host u_nfc_host(.core_clk_in(clk), .nrst_in(nrst), .link(u_nfc_link_if.host),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	nfc_link_props u_nfc_link_props(.core_clk_in(clk), .nrst_in(nrst),
		.req_valid(u_nfc_link_if.req_valid), .req_ready(u_nfc_link_if.req_ready),
		.req_write(u_nfc_link_if.req_write), .req_is_reg(u_nfc_link_if.req_is_reg),
		.req_addr(u_nfc_link_if.req_addr), .req_wdata(u_nfc_link_if.req_wdata),
		.rsp_valid(u_nfc_link_if.rsp_valid), .rsp_rdata(u_nfc_link_if.rsp_rdata),
		.irq(u_nfc_link_if.irq), .busy_out(busy), .sleep_out(sleep));
	// ----------------------------------------
	// clock, timeout and verdict
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// generous: a device order costs some twenty cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			$display("[ERR] %0t timeout", $time);
			num_errors = num_errors + 1;
			end_of_test();
		end
	end
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
			num_errors = num_errors + 1;
		end
	endtask
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				chk({30'h0, bresp}, 32'h0);
				bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic axi_rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				chk({30'h0, rresp}, 32'h0);
				rready <= 1'b0;
				break;
			end
		end
	endtask
	// one link order; waits until it is taken and answered
	task automatic dev_op(input logic wr, input logic rg, input logic [15:0] a,
		input logic [31:0] d, output logic [31:0] q);
		logic [31:0] s;
		axi_wr(5'h04, {16'h0000, a});
		axi_wr(5'h08, d);
		axi_wr(5'h00, {29'h0, rg, wr, 1'b1});
		do axi_rd(5'h0c, s); while (s[1:0] !== 2'b00);
		axi_rd(5'h10, q);
	endtask
	task automatic wreg(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] q;
		dev_op(1'b1, 1'b1, a, d, q);
	endtask
	task automatic wmem(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] q;
		dev_op(1'b1, 1'b0, a, d, q);
	endtask
	task automatic cmem(input logic [15:0] a, input logic [31:0] e);
		logic [31:0] q;
		dev_op(1'b0, 1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic creg(input logic [15:0] a, input logic [31:0] e);
		logic [31:0] q;
		dev_op(1'b0, 1'b1, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic wait_idle();
		logic [31:0] s;
		do dev_op(1'b0, 1'b1, 16'h0002, 32'h0, s); while (s[0] !== 1'b0);
	endtask
	task automatic chk_irq(input logic e);
		logic [31:0] s;
		axi_rd(5'h0c, s);
		chk({31'h0, s[2]}, {31'h0, e});
		axi_wr(5'h0c, 32'h00000002);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] s;
		logic [7:0] codes [6];
		codes = '{8'h51, 8'h91, 8'h61, 8'ha1, 8'h92, 8'ha2};
		{nrst, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata} = 42'h0;
		num_errors = 0;
		num_checks = 0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		creg(16'h0000, 32'h00009000);
		creg(16'h0001, 32'h00000000);
		wreg(16'h0000, 32'h0000900a);
		creg(16'h0000, 32'h00009002);
		foreach (codes[i]) begin
			wreg(16'h0001, {24'h0, codes[i]});
			wreg(16'h0001, {24'h0, codes[i]});
			creg(16'h0001, {24'h0, codes[i]});
			wreg(16'h0001, 32'h00000000);
			creg(16'h0001, 32'h00000000);
		end
		wreg(16'h0001, 32'h00000051);
		wreg(16'h0001, 32'h00000092);
		creg(16'h0001, 32'h00000000);
		// one-shot erase then one-shot write with verify, interrupt on
		wreg(16'h0000, 32'h0000d002);
		chk_irq(1'b0);
		wreg(16'h0001, 32'h00000092);
		wmem(16'h0100, 32'h0);
		wait_idle();
		creg(16'h0001, 32'h00000000);
		cmem(16'h013f, 32'hffffffff);
		chk_irq(1'b1);
		wreg(16'h0001, 32'h00000051);
		for (int i = 0; i < 4; i++) wmem(16'h0100 + 16'(i), 32'ha5a50000 | i);
		wait_idle();
		creg(16'h0001, 32'h00000000);
		dev_op(1'b0, 1'b1, 16'h0002, 32'h0, s);
		chk({27'h0, s[4:0]}, 32'h00000008);
		chk({30'h0, hr_lvl}, 32'h00000001);
		for (int i = 0; i < 4; i++) cmem(16'h0100 + 16'(i), 32'ha5a50000 | i);
		chk_irq(1'b1);
		// block not erased: verify must flag it
		wreg(16'h0001, 32'h00000051);
		for (int i = 0; i < 4; i++) wmem(16'h0100 + 16'(i), ~(32'ha5a50000 | i));
		wait_idle();
		dev_op(1'b0, 1'b1, 16'h0002, 32'h0, s);
		chk({31'h0, s[2]}, 32'h00000001);
		// continuous erase and write, interrupt off
		wreg(16'h0000, 32'h00009000);
		chk_irq(1'b1);
		wreg(16'h0001, 32'h000000a2);
		wmem(16'h0140, 32'h0);
		wmem(16'h0180, 32'h0);
		wreg(16'h0001, 32'h00000000);
		cmem(16'h0180, 32'hffffffff);
		wreg(16'h0001, 32'h000000a1);
		for (int i = 0; i < 4; i++) wmem(16'h0140 + 16'(i), 32'h0f0f0000 | i);
		for (int i = 0; i < 4; i++) wmem(16'h0184 + 16'(i), 32'h3c3c0000 | i);
		wreg(16'h0001, 32'h00000000);
		creg(16'h0001, 32'h00000000);
		cmem(16'h0143, 32'h0f0f0003);
		cmem(16'h0187, 32'h3c3c0003);
		chk_irq(1'b0);
		// protection: three sectors cover word 0x100, two do not
		wreg(16'h0000, 32'h00009030);
		wreg(16'h0001, 32'h00000092);
		wmem(16'h0100, 32'h0);
		dev_op(1'b0, 1'b1, 16'h0002, 32'h0, s);
		chk({31'h0, s[0]}, 32'h00000000);
		cmem(16'h0100, 32'h00000000);
		wreg(16'h0001, 32'h00000000);
		wreg(16'h0000, 32'h00009020);
		wreg(16'h0001, 32'h00000092);
		wmem(16'h0100, 32'h0);
		wait_idle();
		cmem(16'h0100, 32'hffffffff);
		// sleep and wake
		wreg(16'h0000, 32'h0000d000);
		wreg(16'h0001, 32'h000000a1);
		wreg(16'h0000, 32'h00005000);
		do dev_op(1'b0, 1'b1, 16'h0002, 32'h0, s); while (s[1:0] !== 2'b10);
		creg(16'h0001, 32'h00000000);
		wreg(16'h0001, 32'h00000051);
		creg(16'h0001, 32'h00000000);
		wreg(16'h0000, 32'h00005010);
		creg(16'h0000, 32'h00005010);
		chk_irq(1'b0);
		wreg(16'h0000, 32'h0000d000);
		cmem(16'h0143, 32'h0f0f0003);
		wait_idle();
		// failed verify stays flagged until a verified sequence is armed
		creg(16'h0002, 32'h00000004);
		chk_irq(1'b1);
		end_of_test();
	end
endmodule
`default_nettype wire
